/* rtl/nufc_pkg.sv */
// package: flash feature and unique-id host controller constants and types
//==============================================================
// Notes on behaviour
// - id command followed by 00h address, busy
// - after status polling, send read-mode before data
// - xor halves; all FFh accepts, else next
// - random data read may move output pointer
// - feature commands: one address, four parameters
// - ecc bit written zero on fixed-ecc parts
// - valid feature address, then address-to-data wait
// - get features busy; never enhanced status read
package nufc_pkg;

  //==============================================================
  // clock and timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STROBE_NS = 25;
  localparam int HOLD_NS = 15;
  localparam int ADDR_TO_DATA_WAIT_NS = 70;
  localparam int BUSY_ONSET_NS = 100;

  // least times round up to whole cycles
  function automatic int ns_to_cyc(input int ns);
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction : ns_to_cyc

  localparam logic [7:0] STROBE_CYC = 8'(ns_to_cyc(STROBE_NS));
  localparam logic [7:0] HOLD_CYC = 8'(ns_to_cyc(HOLD_NS));
  localparam logic [7:0] ADL_CYC = 8'(ns_to_cyc(ADDR_TO_DATA_WAIT_NS));
  localparam logic [7:0] ONSET_CYC = 8'(ns_to_cyc(BUSY_ONSET_NS));

  //==============================================================
  // flash command bytes and fixed addresses
  localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] ADDR_UNIQUE_ID = 8'h00;
  localparam int STAT_READY_BIT = 6;
  localparam logic [7:0] STAT_LOCK_REPEAT = 8'h60;

  //==============================================================
  // feature map of the target
  localparam logic [7:0] FEAT_TIMING = 8'h01;
  localparam logic [7:0] FEAT_DRIVE = 8'h80;
  localparam logic [7:0] FEAT_BUSY_PULL = 8'h81;
  localparam logic [7:0] FEAT_ARRAY_MODE = 8'h90;
  localparam logic [7:0] TIMING_MODE_MAX = 8'h05;
  localparam logic [7:0] DRIVE_FULL = 8'h00;
  localparam logic [7:0] DRIVE_QUARTER = 8'h03;
  localparam logic [7:0] AOM_RESET = 8'h00;
  localparam logic [7:0] AOM_OTP_PROTECT = 8'h03;
  localparam logic [7:0] AOM_ECC_ENABLE = 8'h08;
  localparam logic [7:0] AOM_LOCK_DISABLE = 8'h10;
  localparam int AOM_ECC_BIT = 3;

  localparam logic [4:0] UID_COPY_BYTES = 5'd31;
  localparam logic [4:0] UID_HALF = 5'd16;
  localparam logic [3:0] UID_LAST_COPY = 4'hF;
  localparam logic [1:0] PARAM_LAST = 2'h3;

  //==============================================================
  // controller registers, word index on the avalon slave
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FEAT_ADDR = 4'h1;
  localparam logic [3:0] REG_PARAM_OUT = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_PARAM_IN = 4'h4;
  localparam logic [3:0] REG_UID0 = 4'h5;
  localparam logic [3:0] REG_UID3 = 4'h8;
  localparam int CTRL_POLL_BIT = 2;
  localparam int CTRL_ECC_FIXED_BIT = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_UID_OK_BIT = 2;
  localparam int ST_UID_FAIL_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;

  //==============================================================
  // types
  typedef enum logic [1:0] {NUFC_OP_UID, NUFC_OP_SET, NUFC_OP_GET, NUFC_OP_NONE} nufc_op_e;
  typedef enum logic [1:0] {NUFC_CYC_CMD, NUFC_CYC_ADDR, NUFC_CYC_WR, NUFC_CYC_RD} nufc_cyc_e;

  typedef struct packed {
    logic valid;
    logic sel;
    nufc_cyc_e kind;
    logic [7:0] data;
  } nufc_cyc_req_s;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io;
    logic io_oe;
  } nufc_pins_s;

  // only the documented feature addresses are sent
  function automatic logic feat_known(input logic [7:0] a);
    return (a == FEAT_TIMING) || (a == FEAT_DRIVE) || (a == FEAT_BUSY_PULL)
      || (a == FEAT_ARRAY_MODE);
  endfunction : feat_known

endpackage : nufc_pkg

/* rtl/nufc_cycle.sv */
// module: one strobed command, address or data cycle on the flash pins
`timescale 1ns/1ps
module nufc_cycle import nufc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from the sequencer
  input wire nufc_cyc_req_s req,
  output logic done,
  output logic [7:0] rdata,
  // flash pins
  input wire logic [7:0] io_in,
  output nufc_pins_s pins
);

  //==============================================================
  // strobe engine
  typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH} nufc_eng_e;

  nufc_eng_e st, next_st;
  logic [7:0] cnt, next_cnt;
  nufc_cyc_e kind, next_kind;
  nufc_pins_s next_pins;
  logic next_done;
  logic [7:0] next_rdata;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_kind = kind;
    next_pins = pins;
    next_done = 1'b0;
    next_rdata = rdata;
    next_pins.ce_n = !req.sel;
    case (st)
      E_IDLE: begin
        if (req.valid) begin
          next_kind = req.kind;
          next_pins.cle = (req.kind == NUFC_CYC_CMD);
          next_pins.ale = (req.kind == NUFC_CYC_ADDR);
          next_pins.io = req.data;
          next_pins.io_oe = (req.kind != NUFC_CYC_RD);
          next_pins.we_n = (req.kind == NUFC_CYC_RD);
          next_pins.re_n = (req.kind != NUFC_CYC_RD);
          next_cnt = STROBE_CYC - 8'h01;
          next_st = E_LOW;
        end
      end
      E_LOW: begin
        if (cnt == 8'h00) begin
          // target latches on the rising write enable
          next_pins.we_n = 1'b1;
          next_pins.re_n = 1'b1;
          if (kind == NUFC_CYC_RD) begin
            next_rdata = io_in;
          end
          next_cnt = HOLD_CYC - 8'h01;
          next_st = E_HIGH;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: begin
        if (cnt == 8'h00) begin
          next_pins.cle = 1'b0;
          next_pins.ale = 1'b0;
          next_pins.io_oe = 1'b0;
          next_done = 1'b1;
          next_st = E_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= E_IDLE;
      cnt <= 8'h00;
      kind <= NUFC_CYC_CMD;
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                io: 8'h00, io_oe: 1'b0};
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      kind <= next_kind;
      pins <= next_pins;
      done <= next_done;
      rdata <= next_rdata;
    end
  end

  //==============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // five cycles follow from the 25 ns strobe at 200 MHz
  we_strobe_width_a: assert property ($fell(pins.we_n) |-> !pins.we_n[*5] ##1 pins.we_n)
    else $error("write enable strobe width wrong");
  io_driven_write_a: assert property (!pins.we_n |-> pins.io_oe && pins.re_n)
    else $error("data not driven during write strobe");

endmodule : nufc_cycle

/* rtl/nufc_host.sv */
// module: host controller for unique-id read and feature set/get commands
`timescale 1ns/1ps
module nufc_host import nufc_pkg::*; (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // flash pins, eight-bit data path
  output logic NAND_CE_N,
  output logic NAND_CLE,
  output logic NAND_ALE,
  output logic NAND_WE_N,
  output logic NAND_RE_N,
  output logic [7:0] NAND_IO_OUT,
  output logic NAND_IO_OE,
  input wire logic [7:0] NAND_IO_IN,
  input wire logic NAND_READY
);

  //==============================================================
  // declarations
  typedef enum logic [3:0] {S_IDLE, S_READY, S_CMD, S_ADDR, S_ADL, S_PARAM, S_ONSET,
    S_BUSY, S_POLL_CMD, S_POLL_RD, S_MODE, S_DATA, S_END} nufc_state_e;

  nufc_state_e state, next_state;
  logic [7:0] cnt, next_cnt;
  logic issued, next_issued;
  logic [4:0] byte_idx, next_byte_idx;
  logic [3:0] copy_idx, next_copy_idx;
  logic copy_ok, next_copy_ok;
  logic uid_ok, next_uid_ok;
  logic uid_fail, next_uid_fail;
  logic done_flag, next_done_flag;
  logic refused, next_refused;
  logic [7:0] status_byte, next_status_byte;
  logic [31:0] param_in, next_param_in;
  logic [7:0] uid_mem [16];
  logic [7:0] next_uid_mem [16];

  logic wait_req, next_wait_req;
  logic [31:0] rdata, next_rdata;
  nufc_op_e op, next_op;
  logic poll_sel, next_poll_sel;
  logic ecc_fixed, next_ecc_fixed;
  logic [7:0] feat_addr, next_feat_addr;
  logic [31:0] param_out, next_param_out;
  logic start, acc;

  nufc_cyc_req_s cyc_req;
  nufc_pins_s pins;
  logic cyc_done;
  logic [7:0] cyc_rdata;

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
    return w[{i, 3'b000} +: 8];
  endfunction : byte_of

  function automatic logic [31:0] uid_word(input logic [7:0] m [16], input logic [1:0] w);
    return {m[{w, 2'h3}], m[{w, 2'h2}], m[{w, 2'h1}], m[{w, 2'h0}]};
  endfunction : uid_word

  //==============================================================
  // avalon slave: answer on the second cycle of every access
  assign acc = (AVS_READ || AVS_WRITE) && !wait_req;

  always_comb begin
    next_wait_req = !((AVS_READ || AVS_WRITE) && wait_req);
    next_rdata = rdata;
    next_op = op;
    next_poll_sel = poll_sel;
    next_ecc_fixed = ecc_fixed;
    next_feat_addr = feat_addr;
    next_param_out = param_out;
    start = 1'b0;
    if (AVS_READ && wait_req) begin
      if (AVS_ADDRESS == REG_CTRL) begin
        next_rdata = {28'h0000000, ecc_fixed, poll_sel, op};
      end else if (AVS_ADDRESS == REG_FEAT_ADDR) begin
        next_rdata = {24'h000000, feat_addr};
      end else if (AVS_ADDRESS == REG_PARAM_OUT) begin
        next_rdata = param_out;
      end else if (AVS_ADDRESS == REG_STATUS) begin
        next_rdata = {12'h000, copy_idx, status_byte, 3'b000, refused, uid_fail, uid_ok,
          done_flag, (state != S_IDLE)};
      end else if (AVS_ADDRESS == REG_PARAM_IN) begin
        next_rdata = param_in;
      end else if (AVS_ADDRESS >= REG_UID0 && AVS_ADDRESS <= REG_UID3) begin
        next_rdata = uid_word(uid_mem, 2'(AVS_ADDRESS - REG_UID0));
      end else begin
        next_rdata = 32'h00000000;
      end
    end
    if (acc && AVS_WRITE && state == S_IDLE) begin
      if (AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0]) begin
        next_op = nufc_op_e'(AVS_WRITEDATA[1:0]);
        next_poll_sel = AVS_WRITEDATA[CTRL_POLL_BIT];
        next_ecc_fixed = AVS_WRITEDATA[CTRL_ECC_FIXED_BIT];
        start = 1'b1;
      end else if (AVS_ADDRESS == REG_FEAT_ADDR && AVS_BYTEENABLE[0]) begin
        next_feat_addr = AVS_WRITEDATA[7:0];
      end else if (AVS_ADDRESS == REG_PARAM_OUT) begin
        for (int b = 0; b < 4; b++) begin
          if (AVS_BYTEENABLE[b]) begin
            next_param_out[b*8 +: 8] = AVS_WRITEDATA[b*8 +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_req <= 1'b1;
      rdata <= 32'h00000000;
      op <= NUFC_OP_NONE;
      poll_sel <= 1'b0;
      ecc_fixed <= 1'b0;
      feat_addr <= FEAT_TIMING;
      param_out <= 32'h00000000;
    end else begin
      wait_req <= next_wait_req;
      rdata <= next_rdata;
      op <= next_op;
      poll_sel <= next_poll_sel;
      ecc_fixed <= next_ecc_fixed;
      feat_addr <= next_feat_addr;
      param_out <= next_param_out;
    end
  end

  //==============================================================
  // command sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_byte_idx = byte_idx;
    next_copy_idx = copy_idx;
    next_copy_ok = copy_ok;
    next_uid_ok = uid_ok;
    next_uid_fail = uid_fail;
    next_done_flag = done_flag;
    next_refused = refused;
    next_status_byte = status_byte;
    next_param_in = param_in;
    next_uid_mem = uid_mem;
    cyc_req = '{valid: 1'b0, sel: (state != S_IDLE), kind: NUFC_CYC_CMD, data: 8'h00};
    case (state)
      S_IDLE: begin
        if (start) begin
          next_done_flag = 1'b0;
          next_uid_ok = 1'b0;
          next_uid_fail = 1'b0;
          next_copy_idx = 4'h0;
          next_copy_ok = 1'b1;
          // a reserved feature address or unknown operation is never sent
          next_refused = (next_op == NUFC_OP_NONE)
            || (next_op != NUFC_OP_UID && !feat_known(feat_addr));
          next_state = next_refused ? S_END : S_READY;
        end
      end
      S_READY: begin
        if (NAND_READY) begin
          next_state = S_CMD;
        end
      end
      S_CMD: begin
        cyc_req.valid = !issued;
        cyc_req.data = (op == NUFC_OP_UID) ? CMD_UNIQUE_ID
          : (op == NUFC_OP_SET) ? CMD_SET_FEAT : CMD_GET_FEAT;
        if (cyc_done) begin
          next_state = S_ADDR;
        end
      end
      S_ADDR: begin
        cyc_req.valid = !issued;
        cyc_req.kind = NUFC_CYC_ADDR;
        cyc_req.data = (op == NUFC_OP_UID) ? ADDR_UNIQUE_ID : feat_addr;
        if (cyc_done) begin
          next_cnt = (op == NUFC_OP_SET) ? ADL_CYC - 8'h01 : ONSET_CYC - 8'h01;
          next_state = (op == NUFC_OP_SET) ? S_ADL : S_ONSET;
          next_byte_idx = 5'd0;
        end
      end
      S_ADL: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_state = S_PARAM;
        end
      end
      S_PARAM: begin
        cyc_req.valid = !issued;
        cyc_req.kind = NUFC_CYC_WR;
        cyc_req.data = byte_of(param_out, byte_idx[1:0]);
        // ecc bit is reserved where ecc cannot be switched
        if (ecc_fixed && feat_addr == FEAT_ARRAY_MODE && byte_idx == 5'd0) begin
          cyc_req.data[AOM_ECC_BIT] = 1'b0;
        end
        if (cyc_done) begin
          next_byte_idx = byte_idx + 5'd1;
          if (byte_idx[1:0] == PARAM_LAST) begin
            next_cnt = ONSET_CYC - 8'h01;
            next_state = S_ONSET;
          end
        end
      end
      S_ONSET: begin
        // ready/busy may lag the last strobe, so it is not looked at yet
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_state = poll_sel ? S_POLL_CMD : S_BUSY;
        end
      end
      S_BUSY: begin
        if (NAND_READY) begin
          next_byte_idx = 5'd0;
          next_state = (op == NUFC_OP_SET) ? S_END : S_DATA;
        end
      end
      S_POLL_CMD: begin
        cyc_req.valid = !issued;
        cyc_req.data = CMD_STATUS;
        if (cyc_done) begin
          next_state = S_POLL_RD;
        end
      end
      S_POLL_RD: begin
        cyc_req.valid = !issued;
        cyc_req.kind = NUFC_CYC_RD;
        if (cyc_done) begin
          next_status_byte = cyc_rdata;
          if (cyc_rdata[STAT_READY_BIT]) begin
            next_byte_idx = 5'd0;
            next_state = (op == NUFC_OP_SET) ? S_END : S_MODE;
          end
        end
      end
      S_MODE: begin
        cyc_req.valid = !issued;
        cyc_req.data = CMD_READ_MODE;
        if (cyc_done) begin
          next_state = S_DATA;
        end
      end
      S_DATA: begin
        cyc_req.valid = !issued;
        cyc_req.kind = NUFC_CYC_RD;
        if (cyc_done) begin
          next_byte_idx = byte_idx + 5'd1;
          if (op == NUFC_OP_GET) begin
            next_param_in[byte_idx[1:0]*8 +: 8] = cyc_rdata;
            if (byte_idx[1:0] == PARAM_LAST) begin
              next_state = S_END;
            end
          end else if (byte_idx < UID_HALF) begin
            next_uid_mem[byte_idx[3:0]] = cyc_rdata;
          end else begin
            // copy pointer runs on sequentially, no random read needed
            if ((cyc_rdata ^ uid_mem[byte_idx[3:0]]) != 8'hFF) begin
              next_copy_ok = 1'b0;
            end
            if (byte_idx == UID_COPY_BYTES) begin
              if (next_copy_ok) begin
                next_uid_ok = 1'b1;
                next_state = S_END;
              end else if (copy_idx == UID_LAST_COPY) begin
                next_uid_fail = 1'b1;
                next_state = S_END;
              end else begin
                next_copy_idx = copy_idx + 4'h1;
                next_copy_ok = 1'b1;
                next_byte_idx = 5'd0;
              end
            end
          end
        end
      end
      default: begin
        next_done_flag = 1'b1;
        next_state = S_IDLE;
      end
    endcase
  end

  assign next_issued = cyc_req.valid ? 1'b1 : (cyc_done ? 1'b0 : issued);

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      issued <= 1'b0;
      byte_idx <= 5'd0;
      copy_idx <= 4'h0;
      copy_ok <= 1'b0;
      uid_ok <= 1'b0;
      uid_fail <= 1'b0;
      done_flag <= 1'b0;
      refused <= 1'b0;
      status_byte <= 8'h00;
      param_in <= 32'h00000000;
      for (int i = 0; i < 16; i++) begin
        uid_mem[i] <= 8'h00;
      end
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      issued <= next_issued;
      byte_idx <= next_byte_idx;
      copy_idx <= next_copy_idx;
      copy_ok <= next_copy_ok;
      uid_ok <= next_uid_ok;
      uid_fail <= next_uid_fail;
      done_flag <= next_done_flag;
      refused <= next_refused;
      status_byte <= next_status_byte;
      param_in <= next_param_in;
      uid_mem <= next_uid_mem;
    end
  end

  //==============================================================
  // pin engine and outputs
  nufc_cycle u_cycle (
    .clk(MCLK),
    .rst_n(RESET_N),
    .req(cyc_req),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .io_in(NAND_IO_IN),
    .pins(pins)
  );

  assign AVS_READDATA = rdata;
  assign AVS_WAITREQUEST = wait_req;
  assign NAND_CE_N = pins.ce_n;
  assign NAND_CLE = pins.cle;
  assign NAND_ALE = pins.ale;
  assign NAND_WE_N = pins.we_n;
  assign NAND_RE_N = pins.re_n;
  assign NAND_IO_OUT = pins.io;
  assign NAND_IO_OE = pins.io_oe;

  //==============================================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  cmd_after_ready_a: assert property ($rose(state == S_CMD) |-> $past(NAND_READY))
    else $error("command issued while target not idle");
  uid_addr_zero_a: assert property ((state == S_ADDR && op == NUFC_OP_UID && cyc_req.valid)
    |-> cyc_req.data == 8'h00)
    else $error("unique id address cycle not 00h");
  read_mode_after_poll_a: assert property ((state == S_POLL_RD && cyc_done
    && cyc_rdata[STAT_READY_BIT] && op != NUFC_OP_SET) |=> state == S_MODE)
    else $error("read mode command missing after polling");
  adl_wait_span_a: assert property ($rose(state == S_ADL) |-> (state == S_ADL)[*8]
    ##[1:8] state == S_PARAM)
    else $error("address to data wait too short");
  four_params_a: assert property ((state == S_PARAM && next_state == S_ONSET)
    |-> byte_idx == 5'd3)
    else $error("parameter phase ended at wrong count");
  ecc_bit_masked_a: assert property ((state == S_PARAM && cyc_req.valid && ecc_fixed
    && feat_addr == 8'h90 && byte_idx == 5'd0) |-> !cyc_req.data[3])
    else $error("ecc bit sent on fixed ecc part");
  no_enhanced_status_a: assert property ((cyc_req.valid && cyc_req.kind == NUFC_CYC_CMD)
    |-> cyc_req.data != 8'h78)
    else $error("enhanced status read issued");
  uid_fail_copies_a: assert property ($rose(uid_fail) |-> $past(copy_idx) == 4'hF)
    else $error("unique id failed before sixteen copies");
  busy_release_a: assert property ((state == S_BUSY && !NAND_READY) |=> state == S_BUSY)
    else $error("busy period left while target busy");

endmodule : nufc_host

/* dv/nufc_flash_model.sv */
// flash target model: unique-id read and feature set/get
`timescale 1ns/1ps
module nufc_flash_model (
  // clock and power
  input wire logic clk,
  input wire logic rst_n,
  // flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io,
  output logic [7:0] io_q,
  output logic ready,
  // bit 0 spoils copy 0 of the id, bit 1 spoils every copy
  input wire logic [1:0] bad
);
  logic pwe, pre, st, bsy, rep;
  logic [1:0] md;
  logic [7:0] fa, last;
  logic [8:0] ptr;
  logic [5:0] cnt;
  logic [31:0] feat [256];
  logic [7:0] ub, q;
  //==============================================================
  // output data
  // only the complement half is spoiled, so the xor of the halves really fails
  assign ub = (ptr[4] ? 8'hFF : 8'h00) ^ {4'hA, ptr[3:0]}
    ^ {7'h00, ptr[4] && (bad[1] || (bad[0] && ptr[8:5] == 4'h0))};
  assign q = st ? {1'b0, ~bsy, rep & ~bsy, 5'h00}
    : (md == 2'h1 ? ub : feat[fa][8*ptr[1:0] +: 8]);
  // released bus shows the inverse so a late sample cannot pass
  assign io_q = re_n ? ~last : q;
  assign ready = ~bsy;
  //==============================================================
  // command decoding on rising write strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {bsy, st, md, fa, last, ptr, cnt, rep} <= '0;
      {pwe, pre} <= 2'h3;
      foreach (feat[i]) feat[i] <= 32'h0;
    end else begin
      pwe <= we_n;
      pre <= re_n;
      if (bsy) begin
        cnt <= cnt + 6'h01;
        if (&cnt) bsy <= 1'b0;
      end
      if (!pre && re_n) begin
        last <= q;
        if (!st) ptr <= ptr + 9'h001;
      end
      if (!pwe && we_n && !ce_n) begin
        if (cle) begin
          // any other command byte leaves status output
          st <= (io == 8'h70);
          if (!bsy && (io == 8'hED || io == 8'hEF || io == 8'hEE)) begin
            md <= io == 8'hED ? 2'h1 : (io == 8'hEF ? 2'h2 : 2'h3);
            ptr <= '0;
          end
        end else if (ale && !bsy) begin
          fa <= io;
          if (md != 2'h2) {bsy, cnt} <= {1'b1, 6'h00};
        end else if (md == 2'h2 && !bsy) begin
          feat[fa][8*ptr[1:0] +: 8] <= io;
          ptr <= ptr + 9'h001;
          if (ptr[1:0] == 2'h0) rep <= fa == 8'h90 && io[4] && feat[fa][4];
          // timing mode writes take the longer interface change busy
          if (ptr[1:0] == 2'h3) {bsy, cnt} <= {1'b1, fa == 8'h01 ? 6'h00 : 6'h20};
        end
      end
    end
  end
endmodule : nufc_flash_model

/* dv/test_nufc_host.sv */
// testbench of the flash unique-id and feature host controller
`timescale 1ns/1ps
module test_nufc_host import nufc_pkg::*;;
  logic MCLK = 0, RESET_N = 0, AVS_READ = 0, AVS_WRITE = 0;
  logic [1:0] bad = 2'h0;
  logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, s;
  logic AVS_WAITREQUEST, NAND_CE_N, NAND_CLE, NAND_ALE, NAND_WE_N, NAND_RE_N;
  logic NAND_IO_OE, NAND_READY;
  logic [7:0] NAND_IO_OUT, NAND_IO_IN;
  int error_cnt = 0, checks = 0;
  always #2.5 MCLK = ~MCLK;
  nufc_host nufc_host_inst (.MCLK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .NAND_CE_N,
    .NAND_CLE, .NAND_ALE, .NAND_WE_N, .NAND_RE_N, .NAND_IO_OUT, .NAND_IO_OE,
    .NAND_IO_IN, .NAND_READY);
  nufc_flash_model nufc_flash_model_inst (.clk(MCLK), .rst_n(RESET_N), .ce_n(NAND_CE_N),
    .cle(NAND_CLE), .ale(NAND_ALE), .we_n(NAND_WE_N), .re_n(NAND_RE_N), .io(NAND_IO_OUT),
    .io_q(NAND_IO_IN), .ready(NAND_READY), .bad(bad));
  //==============================================================
  // shared tasks
  task chk(input string n, input logic [31:0] v, input logic [31:0] e);
    checks++;
    if (v !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
    s = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask : av
  task run(input logic [31:0] c);
    av(1'b1, REG_CTRL, c);
    do av(1'b0, REG_STATUS, 32'h0); while (s[ST_BUSY_BIT] !== 1'b0 || s[ST_DONE_BIT] !== 1'b1);
  endtask : run
  //==============================================================
  // scenarios
  task t_reset;
    av(1'b0, REG_FEAT_ADDR, 32'h0);
    chk("feat_addr", s, 32'h01);
    av(1'b0, 4'hF, 32'h0);
    chk("unmapped", s, 32'h0);
  endtask : t_reset
  task t_feat(input logic [7:0] a, input logic [31:0] p, input logic [31:0] c);
    av(1'b1, REG_FEAT_ADDR, {24'h0, a});
    av(1'b1, REG_PARAM_OUT, p);
    run(32'h2);
    av(1'b0, REG_PARAM_IN, 32'h0);
    chk("default", s, 32'h0);
    run(c);
    chk("stored", nufc_flash_model_inst.feat[a], c[3] ? p & ~32'h8 : p);
    run(32'h2 | (c & 32'h4));
    av(1'b0, REG_PARAM_IN, 32'h0);
    chk("param_in", s, nufc_flash_model_inst.feat[a]);
  endtask : t_feat
  task t_uid(input logic [1:0] b, input logic [31:0] c);
    logic [31:0] e;
    bad <= b;
    run(c);
    chk("uid_ok", s[ST_UID_OK_BIT], {31'h0, !b[1]});
    chk("uid_fail", s[ST_UID_FAIL_BIT], {31'h0, b[1]});
    chk("copy", s[19:16], b[1] ? 32'hF : {31'h0, b[0]});
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) e[8*j +: 8] = 8'hA0 + 8'(4*i + j);
      av(1'b0, REG_UID0 + 4'(i), 32'h0);
      chk("uid", s, e);
    end
  endtask : t_uid
  task t_refuse;
    av(1'b1, REG_FEAT_ADDR, 32'h02);
    run(32'h1);
    chk("refused", s[ST_REFUSED_BIT], 32'h1);
    chk("not sent", nufc_flash_model_inst.feat[2], 32'h0);
  endtask : t_refuse
  // repeats the lock disable left by the array mode scenario, polled
  task t_relock;
    run(32'h5);
    chk("lock_status", s[15:8], {24'h0, STAT_LOCK_REPEAT});
  endtask : t_relock
  //==============================================================
  // main sequence and closing
  task results;
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
    t_reset();
    t_feat(8'h80, 32'h03, 32'h1);
    t_feat(8'h01, 32'h05, 32'h5);
    t_feat(8'h90, 32'h18, 32'h9);
    t_relock();
    t_feat(8'h81, 32'h02, 32'h1);
    t_refuse();
    t_uid(2'h1, 32'h0);
    t_uid(2'h0, 32'h4);
    t_uid(2'h2, 32'h0);
    results();
  end
  // the sixteen-copy id failure is the longest run, some five thousand cycles
  initial begin
    repeat (30000) @(posedge MCLK);
    error_cnt++;
    results();
  end
endmodule : test_nufc_host
